// ---- src/tmr_pkg.sv ----
// Operation
// RQ1: Each timer keeps a 16-bit count, read and written as low and high bytes.
// RQ2: Each timer has its own mode field, and one timer never affects the other.
// RQ3: In 13-bit mode the high byte holds bits 12:5 and low bits 4:0 hold 4:0.
// RQ4: In 13-bit mode a wrap from 0x1FFF to 0x0000 sets the overflow flag.
// RQ5: With the count select bit set, falling edges on the event pin count.
// RQ6: Otherwise the timer ticks on every clock, or on prescale ticks if not selected.
// RQ7: Five clock sources exist: the system clock and four prescaled choices.
// RQ8: External events up to a quarter of the clock rate are counted correctly.
// RQ9: The event source holds each level for at least two clock cycles.
// RQ10: Counting needs run set and either gate select clear or the gate input active.
// RQ11: Timer one is gated by gate input one with its own polarity bit.
// RQ12: Setting run never clears or reloads the count.
// RQ13: 16-bit mode works like 13-bit mode but uses all sixteen bits.
// RQ14: 8-bit reload mode counts low byte; wrap sets flag and reloads from high byte.
// RQ15: Software sets the low byte before enabling 8-bit reload mode.
// RQ16: Timer one behaves like timer zero with its own bytes and control bits.
// RQ17: A set overflow flag with its enable bit set raises that timer's request.
// RQ18: Mode codes: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 inactive here.
// RQ19: Software may clear an overflow flag; vectoring to the handler clears it.
// RQ20: Event and gate pins are synchronised and falls give one-cycle enables.
// RQ21: The prescaled clock arrives as a one-cycle tick from an outside divider.
`default_nettype none
package tmr_pkg;
  // ==========================================================
  // Register map, byte addresses on the APB bus.
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_MODE  = 8'h04;
  localparam logic [7:0] OFS_CLK   = 8'h08;
  localparam logic [7:0] OFS_T0LO  = 8'h0C;
  localparam logic [7:0] OFS_T0HI  = 8'h10;
  localparam logic [7:0] OFS_T1LO  = 8'h14;
  localparam logic [7:0] OFS_T1HI  = 8'h18;
  localparam logic [7:0] OFS_IRQEN = 8'h1C;
  localparam logic [7:0] OFS_POL   = 8'h20;
  // ==========================================================
  // Field positions; per-timer fields add the timer index times the step.
  localparam int RUN_BIT    = 4;
  localparam int FLAG_BIT   = 5;
  localparam int CTRL_STEP  = 2;
  localparam int MODE_LSB   = 0;
  localparam int CNT_BIT    = 2;
  localparam int GATE_BIT   = 3;
  localparam int MODE_STEP  = 4;
  localparam int SYSSEL_BIT = 2;
  localparam int PRESC_LSB  = 0;
  localparam int PRESC_W    = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ==========================================================
  // Operating modes of the two-bit mode field.
  typedef enum logic [1:0] {
    MODE_13  = 2'h0,
    MODE_16  = 2'h1,
    MODE_RLD = 2'h2,
    MODE_OFF = 2'h3
  } tmr_mode_type;
  localparam logic [12:0] TOP_13 = 13'h1FFF;
endpackage
`default_nettype wire

// ---- src/tmr_sync_edge.sv ----
`timescale 1ns/10ps
`default_nettype none
module tmr_sync_edge
  import tmr_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic         core_clk_in,
  input  wire logic         nrst_in,
  input  wire logic [N-1:0] pins_in,
  output logic      [N-1:0] level_out,
  output logic      [N-1:0] fall_out
);
  // ==========================================================
  // Two-stage synchroniser and a delayed copy for edge finding.
  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] prev_q;

  // Only the second stage reads the first, so metastability stays contained.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // A fall gives one pulse, so a quarter-rate input is never missed.
  genvar i;
  for (i = 0; i < N; i++) begin : g_bit
    assign fall_out[i]  = prev_q[i] & ~sync_q[i]; // [RQ20] [RQ8]
    assign level_out[i] = sync_q[i];
  end
endmodule
`default_nettype wire

// ---- src/tmr_count_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module tmr_count_core
  import tmr_pkg::*;
(
  input  wire logic [1:0] mode_in,
  input  wire logic       step_in,
  input  wire logic [7:0] low_in,
  input  wire logic [7:0] high_in,
  output logic      [7:0] low_out,
  output logic      [7:0] high_out,
  output logic            ovf_out
);
  // ==========================================================
  // Next count for one timer; the caller owns the registers.
  logic [13:0] c13;
  logic [16:0] c16;
  logic [8:0]  c8;

  always_comb begin
    c13      = {1'b0, high_in, low_in[4:0]} + 14'h0001;
    c16      = {1'b0, high_in, low_in} + 17'h00001;
    c8       = {1'b0, low_in} + 9'h001;
    low_out  = low_in;
    high_out = high_in;
    ovf_out  = 1'b0;
    if (step_in) begin
      case (tmr_mode_type'(mode_in))
        MODE_13: begin
          // Upper low bits are left alone; software must mask them.
          low_out  = {low_in[7:5], c13[4:0]}; // [RQ3]
          high_out = c13[12:5];
          ovf_out  = c13[13]; // [RQ4]
        end
        MODE_16: begin
          low_out  = c16[7:0]; // [RQ13]
          high_out = c16[15:8];
          ovf_out  = c16[16];
        end
        MODE_RLD: begin
          // The reload value is never touched by the count.
          low_out  = c8[8] ? high_in : c8[7:0]; // [RQ14]
          ovf_out  = c8[8];
        end
        default: begin
          low_out  = low_in; // [RQ18]
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- src/tmr_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tmr_top
  import tmr_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [1:0]  event_pin_in,
  input  wire logic [1:0]  gate_input_in,
  input  wire logic        prescale_tick_in,
  input  wire logic [1:0]  isr_ack_in,
  output logic      [1:0]  prescale_field_out,
  output logic      [1:0]  irq_req_out
);
  // ==========================================================
  // Register state.
  logic [1:0]       flag_q;
  logic [1:0]       run_q;
  logic [3:0]       ext_ctrl_q;
  logic [7:0]       mode_reg_q;
  logic [7:0]       clk_reg_q;
  logic [1:0]       irq_en_q;
  logic [1:0]       pol_q;
  logic [1:0][7:0]  low_q;
  logic [1:0][7:0]  high_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;

  // ==========================================================
  // Bus decode. Zero wait states: every access completes in its
  // access phase, so read data are latched during the setup phase.
  logic       setup;
  logic       wr;
  logic       hit;
  logic [7:0] rd_byte;

  assign setup = psel_in & ~penable_in;
  assign wr    = psel_in & penable_in & pwrite_in & hit;

  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (paddr_in)
      OFS_CTRL: begin
        rd_byte = {flag_q[1], run_q[1], flag_q[0], run_q[0], ext_ctrl_q};
      end
      OFS_MODE: begin
        rd_byte = mode_reg_q;
      end
      OFS_CLK: begin
        rd_byte = clk_reg_q;
      end
      OFS_T0LO: begin
        rd_byte = low_q[0];
      end
      OFS_T0HI: begin
        rd_byte = high_q[0];
      end
      OFS_T1LO: begin
        rd_byte = low_q[1];
      end
      OFS_T1HI: begin
        rd_byte = high_q[1];
      end
      OFS_IRQEN: begin
        rd_byte = {6'h00, irq_en_q};
      end
      OFS_POL: begin
        rd_byte = {6'h00, pol_q};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Read data and the error answer are held through the access phase.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= {24'h00_0000, rd_byte};
      pslverr_q <= ~hit;
    end
  end

  assign pready_out  = 1'b1;
  assign prdata_out  = prdata_q;
  assign pslverr_out = pslverr_q & psel_in & penable_in;

  // ==========================================================
  // Shared configuration registers; the low control nibble belongs
  // to the external interrupt logic and is only stored here.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_ctrl_q <= REG_RESET[3:0];
      mode_reg_q <= REG_RESET;
      clk_reg_q  <= REG_RESET;
      irq_en_q   <= REG_RESET[1:0];
      pol_q      <= REG_RESET[1:0];
    end else if (wr) begin
      case (paddr_in)
        OFS_CTRL: begin
          ext_ctrl_q <= pwdata_in[3:0];
        end
        OFS_MODE: begin
          mode_reg_q <= pwdata_in[7:0];
        end
        OFS_CLK: begin
          clk_reg_q <= pwdata_in[7:0];
        end
        OFS_IRQEN: begin
          irq_en_q <= pwdata_in[1:0];
        end
        OFS_POL: begin
          pol_q <= pwdata_in[1:0];
        end
        default: begin
          ext_ctrl_q <= ext_ctrl_q;
        end
      endcase
    end
  end

  // The outside divider picks one of four ratios from this field.
  assign prescale_field_out = clk_reg_q[PRESC_LSB +: PRESC_W]; // [RQ7] [RQ21]

  // ==========================================================
  // Pin synchronisers: event pins in bits 1:0, gate inputs in 3:2.
  logic [3:0] pin_lvl;
  logic [3:0] pin_fall;

  tmr_sync_edge #(
    .N (4)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .pins_in     ({gate_input_in, event_pin_in}),
    .level_out   (pin_lvl),
    .fall_out    (pin_fall)
  );

  // ==========================================================
  // Per-timer logic; both timers are the same and share nothing
  // but the prescale tick.
  logic [1:0]      step;
  logic [1:0]      ovf;
  logic [1:0]      gate_ok;
  logic [1:0][7:0] low_nx;
  logic [1:0][7:0] high_nx;

  genvar t;
  for (t = 0; t < 2; t++) begin : g_tmr
    localparam logic [7:0] LO_OFS = (t == 0) ? OFS_T0LO : OFS_T1LO;
    localparam logic [7:0] HI_OFS = (t == 0) ? OFS_T0HI : OFS_T1HI;
    logic [1:0] mode;
    logic       cnt_sel;
    logic       gate_sel;
    logic       sys_sel;
    logic       tick;

    assign mode     = mode_reg_q[t*MODE_STEP+MODE_LSB +: 2]; // [RQ2]
    assign cnt_sel  = mode_reg_q[t*MODE_STEP+CNT_BIT];
    assign gate_sel = mode_reg_q[t*MODE_STEP+GATE_BIT];
    assign sys_sel  = clk_reg_q[SYSSEL_BIT+t];

    // Gate input t, active high when its polarity bit is set.
    assign gate_ok[t] = ~(pin_lvl[2+t] ^ pol_q[t]); // [RQ11]

    // Source: event falls, the system clock, or the prescale tick.
    assign tick = cnt_sel ? pin_fall[t] // [RQ5]
                : (sys_sel | prescale_tick_in); // [RQ6]

    // Mode 11 is left to logic outside this block and counts nothing.
    assign step[t] = tick & run_q[t] & (~gate_sel | gate_ok[t]) // [RQ10]
                   & (mode != MODE_OFF); // [RQ18]

    tmr_count_core u_core (
      .mode_in  (mode),
      .step_in  (step[t]),
      .low_in   (low_q[t]),
      .high_in  (high_q[t]),
      .low_out  (low_nx[t]),
      .high_out (high_nx[t]),
      .ovf_out  (ovf[t])
    );

    // Count bytes. A software write wins over a count in the same cycle.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        low_q[t]  <= REG_RESET;
        high_q[t] <= REG_RESET;
      end else begin
        low_q[t]  <= (wr && paddr_in == LO_OFS) ? pwdata_in[7:0] : low_nx[t]; // [RQ1] [RQ16]
        high_q[t] <= (wr && paddr_in == HI_OFS) ? pwdata_in[7:0] : high_nx[t];
      end
    end

    // Run bit; changing it never touches the count.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        run_q[t] <= 1'b0;
      end else if (wr && paddr_in == OFS_CTRL) begin
        run_q[t] <= pwdata_in[RUN_BIT+t*CTRL_STEP]; // [RQ12]
      end
    end

    // Overflow flag: a new overflow beats a clear in the same cycle.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        flag_q[t] <= 1'b0;
      end else if (ovf[t]) begin
        flag_q[t] <= 1'b1; // [RQ4]
      end else if (isr_ack_in[t]) begin
        flag_q[t] <= 1'b0; // [RQ19]
      end else if (wr && paddr_in == OFS_CTRL) begin
        flag_q[t] <= pwdata_in[FLAG_BIT+t*CTRL_STEP]; // [RQ19]
      end
    end

    // Request follows the flag while the enable is set.
    assign irq_req_out[t] = flag_q[t] & irq_en_q[t]; // [RQ17]

    // ========================================================
    // Checks on this timer.
    property p_wrap13;
      @(posedge core_clk_in) disable iff (!nrst_in)
      step[t] && mode == MODE_13 && {high_q[t], low_q[t][4:0]} == TOP_13 && !wr
      |=> flag_q[t] && high_q[t] == 8'h00 && low_q[t][4:0] == 5'h00;
    endproperty
    a_wrap13: assert property (p_wrap13) else $error("13-bit wrap missed"); // [RQ4]

    property p_wrap16;
      @(posedge core_clk_in) disable iff (!nrst_in)
      step[t] && mode == MODE_16 && {high_q[t], low_q[t]} == 16'hFFFF && !wr
      |=> flag_q[t] && {high_q[t], low_q[t]} == 16'h0000;
    endproperty
    a_wrap16: assert property (p_wrap16) else $error("16-bit wrap missed"); // [RQ13]

    property p_reload;
      @(posedge core_clk_in) disable iff (!nrst_in)
      step[t] && mode == MODE_RLD && low_q[t] == 8'hFF && !wr
      |=> flag_q[t] && low_q[t] == $past(high_q[t]) && $stable(high_q[t]);
    endproperty
    a_reload: assert property (p_reload) else $error("8-bit reload wrong"); // [RQ14]

    property p_idle;
      @(posedge core_clk_in) disable iff (!nrst_in)
      (!run_q[t] || mode == MODE_OFF) && !wr |=> $stable(low_q[t]) && $stable(high_q[t]);
    endproperty
    a_idle: assert property (p_idle) else $error("count moved while stopped"); // [RQ10]

    // The pin level two edges back is what the synchroniser shows now.
    property p_gate;
      @(posedge core_clk_in) disable iff (!nrst_in)
      gate_sel && ($past(gate_input_in[t], 2) != pol_q[t]) |-> !step[t];
    endproperty
    a_gate: assert property (p_gate) else $error("count while gate inactive"); // [RQ11]

    property p_event;
      @(posedge core_clk_in) disable iff (!nrst_in)
      cnt_sel && run_q[t] && !gate_sel && mode == MODE_16 && !wr
      |-> ##1 ({high_q[t], low_q[t]} != $past({high_q[t], low_q[t]})) == $past(pin_fall[t]);
    endproperty
    a_event: assert property (p_event) else $error("event count mismatch"); // [RQ5]

    property p_irq;
      @(posedge core_clk_in) disable iff (!nrst_in)
      ovf[t] && irq_en_q[t] |=> irq_req_out[t];
    endproperty
    a_irq: assert property (p_irq) else $error("overflow raised no request"); // [RQ17]

    property p_ack;
      @(posedge core_clk_in) disable iff (!nrst_in)
      isr_ack_in[t] && !ovf[t] |=> !flag_q[t] && !irq_req_out[t];
    endproperty
    a_ack: assert property (p_ack) else $error("flag survived handler entry"); // [RQ19]

    // Software byte writes land whole and win over a count step.
    property p_byte_lo;
      @(posedge core_clk_in) disable iff (!nrst_in)
      wr && paddr_in == LO_OFS |=> low_q[t] == $past(pwdata_in[7:0]);
    endproperty
    a_byte_lo: assert property (p_byte_lo) else $error("low byte write lost"); // [RQ1]

    property p_byte_hi;
      @(posedge core_clk_in) disable iff (!nrst_in)
      wr && paddr_in == HI_OFS |=> high_q[t] == $past(pwdata_in[7:0]);
    endproperty
    a_byte_hi: assert property (p_byte_hi) else $error("high byte write lost"); // [RQ1]

    // Starting the timer must keep whatever software loaded.
    property p_run_keep;
      @(posedge core_clk_in) disable iff (!nrst_in)
      wr && paddr_in == OFS_CTRL && !run_q[t] |=> $stable({high_q[t], low_q[t]});
    endproperty
    a_run_keep: assert property (p_run_keep) else $error("run bit moved count"); // [RQ12]

    // Clock selection: full rate steps every cycle, the prescale path only on its tick.
    property p_clk_src;
      @(posedge core_clk_in) disable iff (!nrst_in)
      run_q[t] && !cnt_sel && sys_sel && !gate_sel && mode == MODE_16 && !wr
      |=> {high_q[t], low_q[t]} == $past({high_q[t], low_q[t]}) + 16'h0001;
    endproperty
    a_clk_src: assert property (p_clk_src) else $error("full-rate step missed"); // [RQ6]

    property p_presc;
      @(posedge core_clk_in) disable iff (!nrst_in)
      run_q[t] && !cnt_sel && !sys_sel && !prescale_tick_in && !wr
      |=> $stable({high_q[t], low_q[t]});
    endproperty
    a_presc: assert property (p_presc) else $error("count moved with no tick"); // [RQ6]

    property p_soft_clr;
      @(posedge core_clk_in) disable iff (!nrst_in)
      wr && paddr_in == OFS_CTRL && !pwdata_in[FLAG_BIT+t*CTRL_STEP] && !ovf[t]
      |=> !flag_q[t];
    endproperty
    a_soft_clr: assert property (p_soft_clr) else $error("flag clear lost"); // [RQ19]

    c_gated: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
      gate_sel && run_q[t] && !gate_ok[t]);

    c_wrap: cover property (@(posedge core_clk_in) disable iff (!nrst_in) ovf[t]);
    c_evt: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
      cnt_sel && step[t]);
    c_race: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
      ovf[t] && isr_ack_in[t]);
  end

  property p_err;
    @(posedge core_clk_in) disable iff (!nrst_in)
    psel_in && penable_in && $past(setup) && $stable(paddr_in) && !$past(hit)
    |-> pslverr_out && prdata_out == 32'h0000_0000;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused"); // [RQ1]
endmodule
`default_nettype wire

// ---- tb/tmr_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Far-side source for the event pins and the gate inputs.
module tmr_pin_model (
  input  wire logic       clk_in,
  output logic      [1:0] event_out,
  output logic      [1:0] gate_out
);
  // Event pins idle high so that the first pulse gives a clean fall.
  initial begin
    event_out = 2'h3;
    gate_out  = 2'h0;
  end
  // Each level stands two full cycles, the fastest legal event rate.
  task pulse(input int n, input int k);
    repeat (k) begin
      @(posedge clk_in);
      event_out[n] <= 1'b0;
      @(posedge clk_in);
      @(posedge clk_in);
      event_out[n] <= 1'b1;
      @(posedge clk_in);
    end
  endtask
  // Gate levels change only on an edge; the bench waits out the synchroniser.
  task set_gate(input int n, input logic v);
    @(posedge clk_in);
    gate_out[n] <= v;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_dual_counter_timer_modes.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_dual_counter_timer_modes
  import tmr_pkg::*;
;
  logic        clk, nrst, psel, penable, pwrite, tick, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  ev, gate, ack, pfield, irq;
  int          fails, n_tests, lo, hi, f;
  // ==========================================================
  // Clock, design and pin source.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  tmr_top DUT (.core_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .event_pin_in(ev), .gate_input_in(gate),
    .prescale_tick_in(tick), .isr_ack_in(ack), .prescale_field_out(pfield),
    .irq_req_out(irq));
  tmr_pin_model PM (.clk_in(clk), .event_out(ev), .gate_out(gate));
  // ==========================================================
  // Comparison and closing report.
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      fails++;
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // APB master: request held until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Prescale ticks are one-cycle pulses with a gap, as from an outside divider.
  task ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask
  // ==========================================================
  // Reference count model, one step per counted event.
  function automatic void model(input int m, input int k, inout int lo, inout int hi,
                                inout int f);
    int c;
    repeat (k) begin
      case (m)
        0: begin
          c = hi * 32 + (lo & 31) + 1;
          if (c == 8192) f = 1;
          hi = (c >> 5) & 255;
          lo = (lo & 224) | (c & 31);
        end
        1: begin
          c = hi * 256 + lo + 1;
          if (c == 65536) f = 1;
          hi = (c >> 8) & 255;
          lo = c & 255;
        end
        2: begin
          if (lo == 255) f = 1;
          lo = (lo == 255) ? hi : lo + 1;
        end
        default: ;
      endcase
    end
  endfunction
  // One timer run: load, start, count k events, then check flag, request and bytes.
  task run_case(input int n, input int m, input int evt, input int gsel, input int gact);
    int k, en, pol, rb;
    k = $urandom_range(1, 12);
    en = $urandom_range(0, 1);
    pol = $urandom_range(0, 3);
    rb = RUN_BIT + CTRL_STEP * n;
    hi = (m == 2) ? $urandom_range(0, 255) : 255;
    lo = 255 - $urandom_range(0, 8);
    f = 0;
    apb(1'b1, OFS_POL, pol);
    PM.set_gate(n, ((pol >> n) & 1) ? gact[0] : !gact[0]);
    apb(1'b1, OFS_IRQEN, en << n);
    apb(1'b1, OFS_MODE, (m | (evt << 2) | (gsel << 3)) << (MODE_STEP * n));
    apb(1'b1, n ? OFS_T1LO : OFS_T0LO, lo);
    apb(1'b1, n ? OFS_T1HI : OFS_T0HI, hi);
    repeat (4) @(posedge clk);
    apb(1'b1, OFS_CTRL, 1 << rb);
    if (evt) PM.pulse(n, k);
    else ticks(k);
    repeat (6) @(posedge clk);
    model(m, (gsel && !gact) ? 0 : k, lo, hi, f);
    chk("irq", (f & en) << n, {30'h0, irq});
    apb(1'b0, OFS_CTRL, 0);
    chk("ctrl", (f * 2 + 1) << rb, rd);
    if (f) begin
      @(posedge clk);
      ack <= 2'(1 << n);
      @(posedge clk);
      ack <= 2'h0;
      apb(1'b0, OFS_CTRL, 0);
      chk("ctrl_ack", 1 << rb, rd);
    end
    apb(1'b1, OFS_CTRL, 0);
    apb(1'b0, n ? OFS_T1LO : OFS_T0LO, 0);
    chk("low", (m == 0) ? (lo & 31) : lo, (m == 0) ? (rd & 31) : rd);
    apb(1'b0, n ? OFS_T1HI : OFS_T0HI, 0);
    chk("high", hi, rd);
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    {psel, penable, pwrite, tick, nrst} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack = 2'h0;
    fails = 0;
    n_tests = 0;
    void'($urandom(25));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chk("irq_rst", 0, {30'h0, irq});
    for (int a = 0; a <= 32; a += 4) begin
      apb(1'b0, 8'(a), 0);
      chk("reset", REG_RESET, rd);
    end
    apb(1'b1, 8'h24, 32'hFF);
    apb(1'b0, 8'h24, 0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    // Software may set both flags; requests follow, and a zero write clears them.
    apb(1'b1, OFS_IRQEN, 32'h3);
    apb(1'b1, OFS_CTRL, (1 << FLAG_BIT) | (1 << (FLAG_BIT + CTRL_STEP)));
    @(negedge clk);
    chk("irq_soft", 32'h3, {30'h0, irq});
    apb(1'b0, OFS_CTRL, 0);
    chk("flag_set", (1 << FLAG_BIT) | (1 << (FLAG_BIT + CTRL_STEP)), rd);
    apb(1'b1, OFS_CTRL, 0);
    apb(1'b0, OFS_CTRL, 0);
    chk("flag_clear", 32'h0, rd);
    for (int x = 0; x < 4; x++) begin
      apb(1'b1, OFS_CLK, x);
      // The field changes at the write edge; look once it has settled.
      @(negedge clk);
      chk("prescale", x, {30'h0, pfield});
    end
    for (int r = 0; r < 2; r++) begin
      for (int n = 0; n < 2; n++) begin
        for (int m = 0; m < 4; m++) run_case(n, m, 0, 0, 0);
        run_case(n, 1, 1, 0, 0);
        run_case(n, 0, 0, 1, 0);
        run_case(n, 2, 1, 1, 1);
      end
    end
    for (int n = 0; n < 2; n++) begin
      apb(1'b1, OFS_CLK, 1 << (SYSSEL_BIT + n));
      apb(1'b1, OFS_MODE, 1 << (MODE_STEP * n));
      apb(1'b1, n ? OFS_T1LO : OFS_T0LO, 0);
      apb(1'b1, n ? OFS_T1HI : OFS_T0HI, 0);
      apb(1'b1, OFS_CTRL, 1 << (RUN_BIT + CTRL_STEP * n));
      repeat (20) @(posedge clk);
      apb(1'b1, OFS_CTRL, 0);
      apb(1'b0, n ? OFS_T1LO : OFS_T0LO, 0);
      // Steps run from the edge after run is set through the edge that clears it:
      // the 20 idle edges plus the three edges of the stopping write.
      chk("fullrate", 32'h17, rd);
    end
    stop_test();
  end
endmodule
`default_nettype wire
